/* rtl/cbcr_pkg.sv */
// Constants for the commutation and brake configuration register bank.
// Assumes a single 250 MHz clock and an active-low asynchronous reset.
package cbcr_pkg;
  localparam logic [7:0] stop_brake_limit_cfg_addr = 8'h88;
  localparam logic [7:0] commutation_degauss_cfg_addr = 8'h8a;
  localparam logic [31:0] stop_brake_limit_cfg_rst = 32'h0000_0000;
  localparam logic [31:0] commutation_degauss_cfg_rst = 32'h1400_0000;
  // Fields of stop_brake_limit_cfg.
  localparam int brake_duty_lsb = 8;
  localparam int surge_guard_bit = 7;
  localparam int current_cap_lsb = 3;
  // Fields of commutation_degauss_cfg.
  localparam int parity_bit = 31;
  localparam int demag_samples_lsb = 29;
  localparam int demag_upper_lsb = 27;
  localparam int demag_lower_lsb = 25;
  localparam int to_zero_crossing_sample_lsb = 23;
  localparam int to_int_sample_lsb = 21;
  localparam int to_zero_crossing_duty_lsb = 19;
  // Sense voltage step of the current cap, in millivolts.
  localparam logic [10:0] current_cap_step_mv = 11'h064;
  // Fewest consecutive samples for the degauss check, at code zero.
  localparam logic [2:0] demag_samples_base = 3'h2;
  typedef enum logic [0:0] {
    cbcr_zero_cross = 1'b0,
    cbcr_integrate = 1'b1
  } cbcr_method_t;
endpackage

/* rtl/cbcr_regs.sv */
// Configuration registers for brake, surge guard, current cap, degauss and commutation switching.
// Assumes duty and voltage inputs come from logic on clk; only the brake pin is asynchronous.
`timescale 1ns/100ps
module cbcr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Brake pin and duty, duty in tenths of a percent
  input wire logic brake_pin,
  input wire logic [9:0] duty_pm,
  output logic brake_apply,
  // Current sense in millivolts
  input wire logic [10:0] sense_mv,
  output logic current_cap_trip,
  output logic surge_guard_on,
  // Degauss sampling in millivolts
  input wire logic demag_start,
  input wire logic demag_sample_vld,
  input wire logic [15:0] phase_mv,
  input wire logic [15:0] supply_mv,
  output logic demag_done,
  // Back-EMF samples per 30 degrees
  input wire logic back_emf_count_vld,
  input wire logic [7:0] back_emf_count,
  output logic integrate_mode
);
  logic [31:0] stop_brake_limit_cfg;
  logic [31:0] commutation_degauss_cfg;
  logic brake_s1, brake_s2, brake_s3, brake_req;
  logic [2:0] demag_cnt;
  cbcr_pkg::cbcr_method_t method;

  function automatic logic [9:0] brake_thr(input logic [2:0] code);
    logic [9:0] t;
    t = 10'h000;
    unique case (code)
      3'h0: t = 10'h3e8;
      3'h1: t = 10'h1f4;
      3'h2: t = 10'h0fa;
      3'h3: t = 10'h096;
      3'h4: t = 10'h064;
      3'h5: t = 10'h04b;
      3'h6: t = 10'h032;
      3'h7: t = 10'h019;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] pick4(input logic [1:0] code, input logic [31:0] tbl);
    return tbl[8*code +: 8];
  endfunction

  wire logic [2:0] brake_code = stop_brake_limit_cfg[cbcr_pkg::brake_duty_lsb +: 3];
  wire logic [3:0] cap_code = stop_brake_limit_cfg[cbcr_pkg::current_cap_lsb +: 4];
  wire logic [1:0] samp_code = commutation_degauss_cfg[cbcr_pkg::demag_samples_lsb +: 2];
  wire logic [1:0] up_code = commutation_degauss_cfg[cbcr_pkg::demag_upper_lsb +: 2];
  wire logic [1:0] lo_code = commutation_degauss_cfg[cbcr_pkg::demag_lower_lsb +: 2];
  wire logic [1:0] zcs_code = commutation_degauss_cfg[cbcr_pkg::to_zero_crossing_sample_lsb +: 2];
  wire logic [1:0] ints_code = commutation_degauss_cfg[cbcr_pkg::to_int_sample_lsb +: 2];
  wire logic [1:0] zcd_code = commutation_degauss_cfg[cbcr_pkg::to_zero_crossing_duty_lsb +: 2];

  // Lookup tables pack four byte-wide entries, code 0 in the low byte.
  wire logic [7:0] upper_off = pick4(up_code, 32'hb4_96_78_5a);
  wire logic [7:0] lower_mv = pick4(lo_code, 32'h78_5a_3c_1e);
  wire logic [7:0] zero_crossing_samples = pick4(zcs_code, 32'h08_06_04_03);
  wire logic [7:0] int_samples = pick4(ints_code, 32'h0a_08_06_04);
  wire logic [7:0] zero_crossing_duty_pc = pick4(zcd_code, 32'h14_12_0f_0c);
  wire logic [9:0] zero_crossing_duty_pm = 10'(zero_crossing_duty_pc) * 10'h00a;
  wire logic [2:0] demag_need = 3'(samp_code) + cbcr_pkg::demag_samples_base;
  wire logic [10:0] cap_mv = 11'(cap_code) * cbcr_pkg::current_cap_step_mv;
  wire logic [15:0] upper_mv = supply_mv - 16'(upper_off);
  wire logic settled = (phase_mv > 16'(lower_mv)) && (phase_mv < upper_mv) && (supply_mv > 16'(upper_off));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stop_brake_limit_cfg <= cbcr_pkg::stop_brake_limit_cfg_rst;
      commutation_degauss_cfg <= cbcr_pkg::commutation_degauss_cfg_rst;
    end else if (reg_wr) begin
      if (reg_addr == cbcr_pkg::stop_brake_limit_cfg_addr) begin
        stop_brake_limit_cfg <= reg_wdata;
      end
      if (reg_addr == cbcr_pkg::commutation_degauss_cfg_addr) begin
        commutation_degauss_cfg <= reg_wdata;
      end
    end
  end

  // Unmapped addresses read as zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == cbcr_pkg::stop_brake_limit_cfg_addr) begin
          reg_rdata <= stop_brake_limit_cfg;
        end else if (reg_addr == cbcr_pkg::commutation_degauss_cfg_addr) begin
          reg_rdata <= commutation_degauss_cfg;
        end else begin
          reg_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // The pin level is taken only when the second and third stages agree, so one glitch cannot brake.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brake_s1 <= 1'b0;
      brake_s2 <= 1'b0;
      brake_s3 <= 1'b0;
      brake_req <= 1'b0;
    end else begin
      brake_s1 <= brake_pin;
      brake_s2 <= brake_s1;
      brake_s3 <= brake_s2;
      if (brake_s2 == brake_s3) begin
        brake_req <= brake_s3;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brake_apply <= 1'b0;
      current_cap_trip <= 1'b0;
      surge_guard_on <= 1'b0;
    end else begin
      brake_apply <= brake_req && ((brake_code == 3'h0) || (duty_pm < brake_thr(brake_code)));
      current_cap_trip <= (cap_code != 4'h0) && (sense_mv >= cap_mv);
      surge_guard_on <= stop_brake_limit_cfg[cbcr_pkg::surge_guard_bit];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      demag_cnt <= 3'h0;
      demag_done <= 1'b0;
    end else if (demag_start) begin
      // A restart outranks a sample in the same cycle, so no sample straddles two check windows.
      demag_cnt <= 3'h0;
      demag_done <= 1'b0;
    end else if (demag_sample_vld && !demag_done) begin
      if (settled) begin
        demag_cnt <= demag_cnt + 3'h1;
        demag_done <= (demag_cnt + 3'h1) >= demag_need;
      end else begin
        demag_cnt <= 3'h0;
      end
    end
  end

  // Separate limits give hysteresis; between them the method holds unless duty_pm drops below zero_crossing_duty_pm.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      method <= cbcr_pkg::cbcr_zero_cross;
    end else begin
      unique case (method)
        cbcr_pkg::cbcr_zero_cross: begin
          if (back_emf_count_vld && (back_emf_count > int_samples)) begin
            method <= cbcr_pkg::cbcr_integrate;
          end
        end
        cbcr_pkg::cbcr_integrate: begin
          if ((back_emf_count_vld && (back_emf_count < zero_crossing_samples)) ||
              (duty_pm < zero_crossing_duty_pm)) begin
            method <= cbcr_pkg::cbcr_zero_cross;
          end
        end
      endcase
    end
  end

  assign integrate_mode = (method == cbcr_pkg::cbcr_integrate);

  brake_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(brake_req) |-> !brake_apply) else $error("brake applied without request");
  brake_now_a: assert property (@(posedge clk) disable iff (!rstn)
    ($past(brake_req) && $past(brake_code) == 3'h0) |-> brake_apply) else $error("immediate brake missing");
  brake_duty_a: assert property (@(posedge clk) disable iff (!rstn)
    ($past(brake_req) && $past(brake_code) == 3'h1 && $past(duty_pm) >= 10'h1f4) |-> !brake_apply)
    else $error("brake above half duty");
  cap_off_a: assert property (@(posedge clk) disable iff (!rstn)
    ($past(cap_code) == 4'h0) |-> !current_cap_trip) else $error("cap tripped while disabled");
  cap_level_a: assert property (@(posedge clk) disable iff (!rstn)
    ($past(cap_code) == 4'h5 && $past(sense_mv) == 11'h1f4) |-> current_cap_trip) else $error("cap at 0.5 V missed");
  cfg_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == cbcr_pkg::commutation_degauss_cfg_addr && !reg_wr) |=>
    (reg_rvalid && reg_rdata == $past(commutation_degauss_cfg))) else $error("degauss config read wrong");
  demag_min_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(demag_done) |-> $past(demag_cnt) + 3'h1 >= $past(demag_need)) else $error("degauss done too early");
  demag_need_a: assert property (@(posedge clk) disable iff (!rstn)
    (!demag_start && demag_sample_vld && !demag_done && settled && demag_cnt + 3'h1 >= demag_need) |=> demag_done)
    else $error("degauss done missing");
  to_int_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(integrate_mode) |-> ($past(back_emf_count_vld) && $past(back_emf_count) > $past(int_samples)))
    else $error("integration entered without crossing");
  to_zero_crossing_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(integrate_mode) |-> (($past(back_emf_count_vld) && $past(back_emf_count) < $past(zero_crossing_samples))
    || $past(duty_pm) < $past(zero_crossing_duty_pm))) else $error("zero crossing entered without crossing");
  duty_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    (integrate_mode && duty_pm < zero_crossing_duty_pm) |=> !integrate_mode) else $error("low duty kept integration");
  hyst_band_a: assert property (@(posedge clk) disable iff (!rstn)
    (back_emf_count_vld && back_emf_count >= zero_crossing_samples && back_emf_count <= int_samples &&
    duty_pm >= zero_crossing_duty_pm) |=> $stable(integrate_mode)) else $error("method changed inside band");
endmodule

/* verif/tb_cbcr_regs.sv */
// Self-checking bench for the commutation and brake configuration registers.
// Assumes the design under rtl/; every input is driven at the falling clock edge.
`timescale 1ns/100ps
module tb_cbcr_regs;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, brake_pin = 1'b0;
  logic demag_start = 1'b0, demag_sample_vld = 1'b0, back_emf_count_vld = 1'b0;
  logic [7:0] reg_addr = 8'h00, back_emf_count = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, cfg;
  logic [9:0] duty_pm = 10'h3e8;
  logic [10:0] sense_mv = 11'h000;
  logic [15:0] phase_mv = 16'h0000, supply_mv = 16'h2ee0;
  logic reg_rvalid, brake_apply, current_cap_trip, surge_guard_on, demag_done, integrate_mode;
  logic [31:0] exp_q[$];
  int n_errors = 0, checks = 0;
  int brk[8] = '{1000, 500, 250, 150, 100, 75, 50, 25};
  int up[4] = '{90, 120, 150, 180}, lo[4] = '{30, 60, 90, 120};
  int hi_n[4] = '{4, 6, 8, 10}, lo_n[4] = '{3, 4, 6, 8}, dty[4] = '{12, 15, 18, 20};
  always #2 clk = ~clk;
  cbcr_regs dut_u (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .brake_pin, .duty_pm, .brake_apply, .sense_mv, .current_cap_trip, .surge_guard_on, .demag_start,
    .demag_sample_vld, .phase_mv, .supply_mv, .demag_done, .back_emf_count_vld, .back_emf_count, .integrate_mode);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1'b1; reg_addr = a; exp_q.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) cyc(1);
    if (exp_q.size() != 0) begin
      n_errors++;
      stop_test();
    end
  endtask
  // Leaves the sample strobe high so back-to-back samples never lower and raise it in one step.
  task automatic pulse_demag(input int mv);
    phase_mv = 16'(mv);
    demag_sample_vld = 1'b1;
    cyc(1);
  endtask
  task automatic back_emf(input int n, input logic e);
    back_emf_count = 8'(n);
    back_emf_count_vld = 1'b1;
    cyc(1);
    back_emf_count_vld = 1'b0;
    cyc(2);
    chk("integrate_mode", integrate_mode, e);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data is compared at the falling edge, well clear of the registered update.
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
      else chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(16));
    cyc(4);
    rstn = 1'b1;
    rd(cbcr_pkg::stop_brake_limit_cfg_addr, 32'h0);
    rd(cbcr_pkg::commutation_degauss_cfg_addr, 32'h1400_0000);
    rd(8'h90, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg = $urandom;
      wr(cbcr_pkg::commutation_degauss_cfg_addr, cfg);
      wr(8'h8c, ~cfg);
      wr(cbcr_pkg::stop_brake_limit_cfg_addr, ~cfg);
      rd(cbcr_pkg::commutation_degauss_cfg_addr, cfg);
      rd(cbcr_pkg::stop_brake_limit_cfg_addr, ~cfg);
    end
    drain();
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      wr(cbcr_pkg::stop_brake_limit_cfg_addr, (32'(c) << 3) | (32'(c & 1) << 7));
      for (int d = 0; d < 2; d++) begin
        sense_mv = 11'(c * 100 - d);
        cyc(3);
        chk("current_cap_trip", current_cap_trip, c != 0 && d == 0);
        chk("surge_guard_on", surge_guard_on, 32'(c & 1));
      end
    end
    $display("test current cap done");
    for (int c = 0; c < 8; c++) begin
      wr(cbcr_pkg::stop_brake_limit_cfg_addr, 32'(c) << 8);
      for (int d = 0; d < 2; d++) begin
        duty_pm = 10'(brk[c] - d);
        brake_pin = 1'b1;
        cyc(8);
        chk("brake_apply", brake_apply, c == 0 || d == 1);
        brake_pin = 1'b0;
        cyc(8);
        chk("brake_apply", brake_apply, 32'h0);
      end
    end
    duty_pm = 10'h3e8;
    $display("test brake done");
    for (int c = 0; c < 4; c++) begin
      wr(cbcr_pkg::commutation_degauss_cfg_addr, 32'(c) * 32'h2aa8_0000);
      demag_start = 1'b1;
      cyc(1);
      demag_start = 1'b0;
      for (int i = 0; i < c + 1; i++) pulse_demag(6000);
      pulse_demag(c[0] ? 12000 - up[c] : lo[c]);
      for (int i = 0; i < c + 1; i++) pulse_demag(6000);
      demag_sample_vld = 1'b0;
      cyc(2);
      chk("demag_done", demag_done, 32'h0);
      pulse_demag(c[0] ? lo[c] + 1 : 11999 - up[c]);
      demag_sample_vld = 1'b0;
      cyc(2);
      chk("demag_done", demag_done, 32'h1);
      back_emf(hi_n[c], 1'b0);
      back_emf(hi_n[c] + 1, 1'b1);
      back_emf(lo_n[c], 1'b1);
      back_emf(lo_n[c] - 1, 1'b0);
      back_emf(hi_n[c] + 1, 1'b1);
      duty_pm = 10'(dty[c] * 10);
      cyc(3);
      chk("integrate_mode", integrate_mode, 32'h1);
      duty_pm = 10'(dty[c] * 10 - 1);
      cyc(3);
      chk("integrate_mode", integrate_mode, 32'h0);
      duty_pm = 10'h3e8;
    end
    $display("test degauss and commutation done");
    stop_test();
  end
endmodule
